// ==== spi_wake_defines.svh ====
// shared constants for the spi host link wake-up handshake
`ifndef SPI_WAKE_DEFINES_SVH
`define SPI_WAKE_DEFINES_SVH

// indicator bytes and frame codes
`define IND_WRITE       8'h01
`define IND_READ        8'h03
`define TFI_HOST        8'hD4
`define CC_GEN_STATUS   8'h04
`define CC_SECURE_CFG   8'h14
`define CC_SLEEP        8'h16
`define CC_TARGET_INIT  8'h8C
`define SEC_MODE_NORMAL 8'h01
`define SEC_MODE_VCARD  8'h02
`define SEC_MODE_LOWBAT 8'h05
`define SEC_NO_TIMEOUT  8'h00

// timing in own units, then in cycles of the 200 MHz clock
`define CLK_MHZ         200
`define OSC_START_US    2000
`define OSC_START_CYC   (`OSC_START_US * `CLK_MHZ)
`define SLEEP_ENTRY_US  1000
`define SLEEP_ENTRY_CYC (`SLEEP_ENTRY_US * `CLK_MHZ)
`define WAKEUP_WAIT_US  2010
`define WAKEUP_WAIT_CYC (`WAKEUP_WAIT_US * `CLK_MHZ)
`define REQ_PULSE_NS    1000
`define REQ_PULSE_CYC   ((`REQ_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define SCK_HALF_CYC    5

`endif

// ==== spi_wake_pkg.sv ====
// types shared by both ends of the spi wake-up link
package spi_wake_pkg;
	typedef enum logic [1:0] {PW_SLEEP, PW_WAKING, PW_AWAKE, PW_GOING} dev_pwr_e;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_VCARD, MODE_LOWBAT} link_mode_e;
	typedef enum logic [2:0] {HS_IDLE, HS_REQ_PULSE, HS_WAKE_WAIT, HS_CS_HOLD,
		HS_LOAD, HS_SHIFT, HS_END} host_st_e;
endpackage : spi_wake_pkg

// ==== spi_wake_if.sv ====
// pins between host controller and device: spi plus irq and request lines
`timescale 1ns/1ps
interface spi_wake_if;
	logic spi_sck;
	logic spi_cs_n;
	logic spi_mosi;
	logic spi_miso;
	logic host_irq_n;
	logic host_request_n;

	modport device (
		input  spi_sck, spi_cs_n, spi_mosi, host_request_n,
		output spi_miso, host_irq_n
	);
	modport host (
		output spi_sck, spi_cs_n, spi_mosi, host_request_n,
		input  spi_miso, host_irq_n
	);
endinterface : spi_wake_if

// ==== spi_wake_device.sv ====
// device end: spi slave on the link clock, wake and irq logic on own clock
`timescale 1ns/1ps
`include "spi_wake_defines.svh"

// What this block does
// - sleep after reset or virtual-card setup
// - secure-module event pulls irq low unsolicited in virtual card
// - general status command releases irq
// - host sends virtual-card config, waits irq
// - host never mixes virtual-card with sleep
// - host may use request line in virtual-card
// - sleep entry takes 1 ms after response
// - link is spi plus irq and request
// - low battery: ignore request, no secure reports
// - low battery: host holds select low first
// - awake: irq low when answer ready
// - request wakes sleeper, irq acknowledges immediately
// - host waits or polls irq with timeout
// - write indicator after wake releases irq
// - ack, then irq when response ready
// - read indicator releases irq
// - without request line, select low wakes
// - target init sleeps without field, wakes
// - target activation raises irq to host, except in low battery
// - request pulse sent only to wake a sleeper, always OSC_CYC + 1 cycles long
module spi_wake_device #(
	parameter int unsigned OSC_CYC   = `OSC_START_CYC,
	parameter int unsigned SLEEP_CYC = `SLEEP_ENTRY_CYC
) (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// link pins
	spi_wake_if.device      link,
	// firmware side
	input  wire logic       i_resp_ready,
	input  wire logic       i_tx_load,
	input  wire logic [7:0] i_tx_byte,
	input  wire logic       i_secure_event,
	input  wire logic       i_target_active,
	input  wire logic       i_rf_field,
	output logic      [7:0] o_rx_byte,
	output logic            o_rx_valid,
	output logic            o_awake,
	output logic      [1:0] o_mode
);
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic [7:0] rxb_q;
	logic       rxt_q;
	logic [7:0] txs_q;
	logic       miso_q;
	logic       link_rst;
	logic [7:0] tx_word_q;
	logic       req_s1_q, req_s2_q, req_s3_q;
	logic       cs_s1_q, cs_s2_q, cs_s3_q;
	logic       rxt_s1_q, rxt_s2_q, rxt_s3_q;
	logic       req_fall, cs_fall, cs_rise, rx_stb;
	logic [7:0] h0_q, h1_q;
	logic [3:0] idx_q;
	logic       ind_write, ind_read, gen_status;
	logic       read_frame_q;
	logic       target_q;
	logic       irq_n_q;
	logic       irq_set, irq_clr;
	logic       pd_arm;
	logic [31:0] cnt_q;
	spi_wake_pkg::dev_pwr_e   pwr_q;
	spi_wake_pkg::link_mode_e mode_q;

	// link domain: shifter is held clear while select is high
	assign link_rst = i_sys_rst | link.spi_cs_n;

	// bit counter and receive shifter on rising sck
	always_ff @(posedge link.spi_sck or posedge link_rst) begin
		if (link_rst) begin
			bit_q <= 3'h0;
			sh_q  <= 8'h00;
		end else begin
			bit_q <= bit_q + 3'h1;
			sh_q  <= {sh_q[6:0], link.spi_mosi};
		end
	end

	// finished byte held stable, toggle marks it for the core domain
	always_ff @(posedge link.spi_sck or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rxb_q <= 8'h00;
			rxt_q <= 1'b0;
		end else if (bit_q == 3'h7) begin
			rxb_q <= {sh_q[6:0], link.spi_mosi};
			rxt_q <= ~rxt_q;
		end
	end

	// miso shifts on falling sck; next byte loads at the byte boundary
	always_ff @(negedge link.spi_sck or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			miso_q <= 1'b0;
			txs_q  <= 8'h00;
		end else if (bit_q == 3'h0) begin
			miso_q <= tx_word_q[7]; // word is quasi-static, loaded between bytes
			txs_q  <= {tx_word_q[6:0], 1'b0};
		end else begin
			miso_q <= txs_q[7];
			txs_q  <= {txs_q[6:0], 1'b0};
		end
	end

	assign link.spi_miso   = miso_q;
	assign link.host_irq_n = irq_n_q;

	// three-flop synchronisers for the request and select pins and the byte toggle
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			{req_s1_q, req_s2_q, req_s3_q} <= 3'h7;
			{cs_s1_q, cs_s2_q, cs_s3_q}    <= 3'h7;
			{rxt_s1_q, rxt_s2_q, rxt_s3_q} <= 3'h0;
		end else begin
			{req_s1_q, req_s2_q, req_s3_q} <= {link.host_request_n, req_s1_q, req_s2_q};
			{cs_s1_q, cs_s2_q, cs_s3_q}    <= {link.spi_cs_n, cs_s1_q, cs_s2_q};
			{rxt_s1_q, rxt_s2_q, rxt_s3_q} <= {rxt_q, rxt_s1_q, rxt_s2_q};
		end
	end

	// edges judged on the second and third stages only
	assign req_fall = req_s3_q & ~req_s2_q;
	assign cs_fall  = cs_s3_q & ~cs_s2_q;
	assign cs_rise  = ~cs_s3_q & cs_s2_q;
	assign rx_stb   = rxt_s2_q ^ rxt_s3_q;

	// frame decode: indicator is the first byte after select falls
	assign ind_write  = rx_stb && idx_q == 4'h0 && rxb_q == `IND_WRITE;
	assign ind_read   = rx_stb && idx_q == 4'h0 && rxb_q == `IND_READ;
	assign gen_status = rx_stb && h0_q == `TFI_HOST && rxb_q == `CC_GEN_STATUS;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			idx_q      <= 4'h0;
			h0_q       <= 8'h00;
			h1_q       <= 8'h00;
			o_rx_byte  <= 8'h00;
			o_rx_valid <= 1'b0;
		end else begin
			o_rx_valid <= rx_stb;
			if (cs_fall) begin
				idx_q <= 4'h0;
				h0_q  <= 8'h00;
				h1_q  <= 8'h00;
			end else if (rx_stb) begin
				if (idx_q != 4'hF) begin
					idx_q <= idx_q + 4'h1;
				end
				h0_q      <= rxb_q;
				h1_q      <= h0_q;
				o_rx_byte <= rxb_q;
			end
		end
	end

	// mode from the secure-module configuration command
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mode_q <= spi_wake_pkg::MODE_VCARD;
		end else if (rx_stb && h1_q == `TFI_HOST && h0_q == `CC_SECURE_CFG) begin
			unique case (rxb_q)
				`SEC_MODE_VCARD:  mode_q <= spi_wake_pkg::MODE_VCARD;
				`SEC_MODE_LOWBAT: mode_q <= spi_wake_pkg::MODE_LOWBAT;
				default:          mode_q <= spi_wake_pkg::MODE_NORMAL;
			endcase
		end
	end

	// target init arms sleep until an initiator activates us
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			target_q <= 1'b0;
		end else if (rx_stb && h0_q == `TFI_HOST && rxb_q == `CC_TARGET_INIT) begin
			target_q <= 1'b1;
		end else if (i_target_active) begin
			target_q <= 1'b0;
		end
	end

	// remember a read frame so its end can start the sleep timer
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			read_frame_q <= 1'b0;
		end else if (ind_read) begin
			read_frame_q <= 1'b1;
		end else if (cs_rise) begin
			read_frame_q <= 1'b0;
		end
	end

	// response word handed to the link domain
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tx_word_q <= 8'h00;
		end else if (i_tx_load) begin
			tx_word_q <= i_tx_byte;
		end
	end

	// irq causes; low battery keeps only host-exchange answers
	always_comb begin
		irq_set = i_resp_ready;
		if (mode_q != spi_wake_pkg::MODE_LOWBAT) begin
			irq_set = irq_set
				| (req_fall && pwr_q == spi_wake_pkg::PW_SLEEP)
				| (i_secure_event && mode_q == spi_wake_pkg::MODE_VCARD)
				| i_target_active;
		end
	end
	assign irq_clr = ind_write | ind_read | gen_status;

	// set beats clear so no event is lost
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= ~(irq_set | (~irq_n_q & ~irq_clr));
		end
	end

	// sleep is allowed in virtual card, low battery, or idle target
	assign pd_arm = mode_q != spi_wake_pkg::MODE_NORMAL || (target_q && !i_rf_field);

	// power state: oscillator restart on wake, delayed sleep entry
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pwr_q <= spi_wake_pkg::PW_SLEEP;
			cnt_q <= 32'h0;
		end else begin
			unique case (pwr_q)
				spi_wake_pkg::PW_SLEEP: begin
					// select held low wakes when no request line is used
					if ((req_fall && mode_q != spi_wake_pkg::MODE_LOWBAT)
							|| cs_fall
							|| (target_q && i_rf_field)
							|| (i_secure_event && mode_q == spi_wake_pkg::MODE_VCARD)) begin
						pwr_q <= spi_wake_pkg::PW_WAKING;
						cnt_q <= OSC_CYC;
					end
				end
				spi_wake_pkg::PW_WAKING: begin
					if (cnt_q == 32'h0) begin
						pwr_q <= spi_wake_pkg::PW_AWAKE;
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				spi_wake_pkg::PW_AWAKE: begin
					if (cs_rise && read_frame_q && pd_arm) begin
						pwr_q <= spi_wake_pkg::PW_GOING;
						cnt_q <= SLEEP_CYC;
					end
				end
				spi_wake_pkg::PW_GOING: begin
					// host traffic during entry pulls us back awake
					if (cs_fall || req_fall || !pd_arm) begin
						pwr_q <= spi_wake_pkg::PW_AWAKE;
					end else if (cnt_q == 32'h0) begin
						pwr_q <= spi_wake_pkg::PW_SLEEP;
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
			endcase
		end
	end

	// status seen by the firmware
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_awake <= 1'b0;
			o_mode  <= 2'h1; // matches the reset mode, virtual card
		end else begin
			// still awake while sleep entry counts down
			o_awake <= pwr_q == spi_wake_pkg::PW_AWAKE || pwr_q == spi_wake_pkg::PW_GOING;
			o_mode  <= mode_q;
		end
	end
endmodule : spi_wake_device

// ==== spi_wake_host.sv ====
// host end: spi master with wake pulse, select hold and irq wait
`timescale 1ns/1ps
`include "spi_wake_defines.svh"

module spi_wake_host #(
	parameter int unsigned OSC_CYC   = `OSC_START_CYC,
	parameter int unsigned WUP_CYC   = `WAKEUP_WAIT_CYC,
	parameter int unsigned SLEEP_CYC = `SLEEP_ENTRY_CYC
) (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// link pins
	spi_wake_if.host        link,
	// user side
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_byte,
	input  wire logic       i_tx_last,
	input  wire logic       i_wake,
	input  wire logic       i_req_wired,
	input  wire logic       i_low_batt,
	output logic            o_tx_ready,
	output logic      [7:0] o_rx_byte,
	output logic            o_rx_valid,
	output logic            o_irq,
	output logic            o_refused
);
	logic        irq_s1_q, irq_s2_q;
	logic        miso_s1_q, miso_s2_q;
	logic        sck_q, cs_n_q, mosi_q, req_n_q;
	logic [7:0]  sh_q;
	logic [2:0]  bit_q;
	logic        last_q;
	logic [31:0] cnt_q;
	logic [31:0] quiet_q;
	logic [23:0] hist_q;
	logic        vcard_q;
	logic        first_q;
	logic        read_q;
	spi_wake_pkg::host_st_e st_q;

	assign link.spi_sck        = sck_q;
	assign link.spi_cs_n       = cs_n_q;
	assign link.spi_mosi       = mosi_q;
	assign link.host_request_n = req_n_q;

	// pins from the device pass two flops
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			{irq_s1_q, irq_s2_q}   <= 2'h3;
			{miso_s1_q, miso_s2_q} <= 2'h0;
			o_irq                  <= 1'b0;
		end else begin
			{irq_s1_q, irq_s2_q}   <= {link.host_irq_n, irq_s1_q};
			{miso_s1_q, miso_s2_q} <= {link.spi_miso, miso_s1_q};
			o_irq                  <= ~irq_s2_q; // user answers with general status
		end
	end

	// remember virtual-card setup from the bytes we send
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hist_q  <= 24'h0;
			vcard_q <= 1'b0;
		end else if (o_tx_ready) begin
			hist_q <= {hist_q[15:0], sh_q};
			if ({hist_q, sh_q} == {`TFI_HOST, `CC_SECURE_CFG, `SEC_MODE_VCARD, `SEC_NO_TIMEOUT}) begin
				vcard_q <= 1'b1;
			end else if (hist_q[15:0] == {`TFI_HOST, `CC_SECURE_CFG}) begin
				vcard_q <= 1'b0;
			end
		end
	end

	// quiet time after a read frame while the device may fall asleep
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			quiet_q <= 32'h0;
		end else if (st_q == spi_wake_pkg::HS_END && cnt_q == 32'h0 && read_q) begin
			quiet_q <= SLEEP_CYC;
		end else if (quiet_q != 32'h0) begin
			quiet_q <= quiet_q - 32'h1;
		end
	end

	// frame sequencer and sck divider
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q       <= spi_wake_pkg::HS_IDLE;
			sck_q      <= 1'b0;
			cs_n_q     <= 1'b1;
			mosi_q     <= 1'b0;
			req_n_q    <= 1'b1;
			sh_q       <= 8'h00;
			bit_q      <= 3'h0;
			last_q     <= 1'b0;
			cnt_q      <= 32'h0;
			first_q    <= 1'b0;
			read_q     <= 1'b0;
			o_tx_ready <= 1'b0;
			o_rx_byte  <= 8'h00;
			o_rx_valid <= 1'b0;
			o_refused  <= 1'b0;
		end else begin
			o_tx_ready <= 1'b0;
			o_rx_valid <= 1'b0;
			o_refused  <= 1'b0;
			unique case (st_q)
				spi_wake_pkg::HS_IDLE: begin
					first_q <= 1'b1;
					read_q  <= 1'b0;
					if (i_tx_valid && quiet_q == 32'h0) begin
						if (i_wake && i_req_wired && !i_low_batt) begin
							req_n_q <= 1'b0;
							cnt_q   <= OSC_CYC; // long enough for a sleeper
							st_q    <= spi_wake_pkg::HS_REQ_PULSE;
						end else if (i_wake || i_low_batt) begin
							cs_n_q <= 1'b0;
							cnt_q  <= OSC_CYC;
							st_q   <= spi_wake_pkg::HS_CS_HOLD;
						end else begin
							cs_n_q <= 1'b0;
							st_q   <= spi_wake_pkg::HS_LOAD;
						end
					end
				end
				spi_wake_pkg::HS_REQ_PULSE: begin
					if (cnt_q == 32'h0) begin
						req_n_q <= 1'b1;
						cnt_q   <= WUP_CYC;
						st_q    <= spi_wake_pkg::HS_WAKE_WAIT;
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				spi_wake_pkg::HS_WAKE_WAIT: begin
					// poll the acknowledge, give up after the wake-up wait
					if (!irq_s2_q || cnt_q == 32'h0) begin
						cs_n_q <= 1'b0;
						st_q   <= spi_wake_pkg::HS_LOAD;
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				spi_wake_pkg::HS_CS_HOLD: begin
					if (cnt_q == 32'h0) begin
						st_q <= spi_wake_pkg::HS_LOAD;
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				spi_wake_pkg::HS_LOAD: begin
					// sck stays low until the user offers the next byte
					if (i_tx_valid) begin
						o_tx_ready <= 1'b1;
						cnt_q      <= `SCK_HALF_CYC - 1;
						// last byte sent, not the shifter, which now holds miso data
						if (vcard_q && hist_q[7:0] == `TFI_HOST && i_tx_byte == `CC_SLEEP) begin
							o_refused <= 1'b1;
							st_q      <= spi_wake_pkg::HS_END;
						end else begin
							sh_q    <= i_tx_byte;
							mosi_q  <= i_tx_byte[7];
							last_q  <= i_tx_last;
							bit_q   <= 3'h0;
							first_q <= 1'b0;
							if (first_q && i_tx_byte == `IND_READ) begin
								read_q <= 1'b1;
							end
							st_q <= spi_wake_pkg::HS_SHIFT;
						end
					end
				end
				spi_wake_pkg::HS_SHIFT: begin
					if (cnt_q == 32'h0) begin
						cnt_q <= `SCK_HALF_CYC - 1;
						sck_q <= ~sck_q;
						// falling edge: take miso, present next mosi bit
						if (sck_q) begin
							sh_q   <= {sh_q[6:0], miso_s2_q};
							mosi_q <= sh_q[6];
							bit_q  <= bit_q + 3'h1;
							if (bit_q == 3'h7) begin
								o_rx_byte  <= {sh_q[6:0], miso_s2_q};
								o_rx_valid <= 1'b1;
								st_q       <= last_q ? spi_wake_pkg::HS_END
								                     : spi_wake_pkg::HS_LOAD;
							end
						end
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				spi_wake_pkg::HS_END: begin
					if (cnt_q == 32'h0) begin
						cs_n_q <= 1'b1;
						st_q   <= spi_wake_pkg::HS_IDLE;
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				default: st_q <= spi_wake_pkg::HS_IDLE;
			endcase
		end
	end
endmodule : spi_wake_host

// ==== spi_wake_chk.sv ====
// concurrent checks on the pins of the spi wake-up link
`timescale 1ns/1ps
`include "spi_wake_defines.svh"
module spi_wake_chk #(
	parameter int unsigned OSC_CYC = 50
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// link pins
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic spi_miso,
	input wire logic host_irq_n,
	input wire logic host_request_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	logic [31:0] req_cnt_q;
	logic        sck_q;
	logic        done_q;
	logic [2:0]  bit_q;
	logic [1:0]  idx_q;
	logic [7:0]  sh_q;
	logic [7:0]  prev_q;
	logic [7:0]  ind_q;

	// length of each low request pulse, in clock cycles
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) req_cnt_q <= '0;
		else req_cnt_q <= host_request_n ? '0 : req_cnt_q + 1;
	end

	// byte rebuild from mosi; sck is a flop of this clock so edges are seen cleanly
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sck_q  <= 1'b0;
			done_q <= 1'b0;
			bit_q  <= '0;
			sh_q   <= '0;
		end else if (spi_cs_n) begin
			sck_q  <= 1'b0;
			done_q <= 1'b0;
			bit_q  <= '0;
			sh_q   <= '0;
		end else begin
			sck_q  <= spi_sck;
			done_q <= spi_sck && !sck_q && bit_q == 3'h7;
			if (spi_sck && !sck_q) begin
				sh_q  <= {sh_q[6:0], spi_mosi};
				bit_q <= bit_q + 3'h1;
			end
		end
	end

	// byte index within the frame, previous byte and leading indicator
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			idx_q  <= '0;
			prev_q <= '0;
			ind_q  <= '0;
		end else if (spi_cs_n) begin
			idx_q  <= '0;
			prev_q <= '0;
			ind_q  <= '0;
		end else if (done_q) begin
			idx_q  <= (idx_q == 2'h3) ? idx_q : idx_q + 2'h1;
			prev_q <= sh_q;
			if (idx_q == 2'h0) ind_q <= sh_q;
		end
	end

	sck_idle_a: assert property (spi_cs_n |-> !spi_sck)
		else $error("sck not idle low while deselected");
	sck_high_a: assert property ($rose(spi_sck) |=> spi_sck[*4] ##1 !spi_sck)
		else $error("sck high phase length wrong");
	mosi_hold_a: assert property (spi_sck && $past(spi_sck) |-> $stable(spi_mosi))
		else $error("mosi moved while sck high");
	miso_hold_a: assert property (spi_sck && $past(spi_sck) |-> $stable(spi_miso))
		else $error("miso moved while sck high");
	cs_lead_a: assert property ($fell(spi_cs_n) |-> !spi_sck[*4])
		else $error("sck started too soon after select");
	req_len_a: assert property ($rose(host_request_n) |-> req_cnt_q >= OSC_CYC)
		else $error("request pulse too short");
	req_idle_a: assert property (!host_request_n |-> spi_cs_n)
		else $error("request overlaps a frame");
	wake_ack_a: assert property ($fell(host_request_n) |-> ##[1:6] !host_irq_n)
		else $error("request not acknowledged on irq");
	ind_release_a: assert property (done_q && idx_q == 2'h0
		&& (sh_q == `IND_WRITE || sh_q == `IND_READ) |-> ##[0:10] host_irq_n)
		else $error("irq kept low after indicator byte");
	status_release_a: assert property (done_q && idx_q == 2'h2 && ind_q == `IND_WRITE
		&& prev_q == `TFI_HOST && sh_q == `CC_GEN_STATUS |-> ##[0:10] host_irq_n)
		else $error("irq kept low after status command");
endmodule : spi_wake_chk

// ==== test_spi_host_wakeup_handshake.sv ====
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`include "spi_wake_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_spi_host_wakeup_handshake;
	localparam int unsigned OSC = 50;
	localparam int unsigned SLP = 100;
	logic       i_clk, i_sys_rst, h_tx_valid, h_tx_last, h_wake, h_req_wired, h_low_batt;
	logic       h_tx_ready, h_rx_valid, h_irq, h_refused, d_rx_valid, d_awake;
	logic       d_resp_ready, d_tx_load, d_sec_event, d_tgt_active, d_rf_field;
	logic [7:0] h_tx_byte, h_rx_byte, d_tx_byte, d_rx_byte;
	logic [1:0] d_mode;
	logic [7:0] hq[$], dq[$];
	logic [7:0] modes[3] = '{`SEC_MODE_NORMAL, `SEC_MODE_VCARD, `SEC_MODE_LOWBAT};
	int         err_count, tests_run, cyc, refused_n, lead, last_lead;
	logic       seen;

	spi_wake_if spi_wake_if_i();
	spi_wake_host #(.OSC_CYC(OSC), .WUP_CYC(60), .SLEEP_CYC(SLP)) spi_wake_host_i (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(spi_wake_if_i),
		.i_tx_valid(h_tx_valid), .i_tx_byte(h_tx_byte), .i_tx_last(h_tx_last),
		.i_wake(h_wake), .i_req_wired(h_req_wired), .i_low_batt(h_low_batt),
		.o_tx_ready(h_tx_ready), .o_rx_byte(h_rx_byte), .o_rx_valid(h_rx_valid),
		.o_irq(h_irq), .o_refused(h_refused));
	spi_wake_device #(.OSC_CYC(OSC), .SLEEP_CYC(SLP)) spi_wake_device_i (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(spi_wake_if_i),
		.i_resp_ready(d_resp_ready), .i_tx_load(d_tx_load), .i_tx_byte(d_tx_byte),
		.i_secure_event(d_sec_event), .i_target_active(d_tgt_active),
		.i_rf_field(d_rf_field), .o_rx_byte(d_rx_byte), .o_rx_valid(d_rx_valid),
		.o_awake(d_awake), .o_mode(d_mode));
	spi_wake_chk #(.OSC_CYC(OSC)) spi_wake_chk_i (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .spi_sck(spi_wake_if_i.spi_sck),
		.spi_cs_n(spi_wake_if_i.spi_cs_n), .spi_mosi(spi_wake_if_i.spi_mosi),
		.spi_miso(spi_wake_if_i.spi_miso), .host_irq_n(spi_wake_if_i.host_irq_n),
		.host_request_n(spi_wake_if_i.host_request_n));

	// clock; half of the 5 ns period
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// byte capture, refusal count, select lead time and the hang guard
	always @(posedge i_clk) begin
		if (h_rx_valid) hq.push_back(h_rx_byte);
		if (d_rx_valid) dq.push_back(d_rx_byte);
		if (h_refused) refused_n++;
		if (spi_wake_if_i.spi_cs_n) begin
			lead = 0;
			seen = 1'b0;
		end else if (spi_wake_if_i.spi_sck && !seen) begin
			seen = 1'b1;
			last_lead = lead;
		end else if (!seen) lead++;
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge i_clk);
			#1;
		end
	endtask : tick

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse

	task automatic wait_irq(input logic v, input int lim);
		int n;
		n = 0;
		while (h_irq !== v && n < lim) begin
			tick(1);
			n++;
		end
		`CHK(h_irq, v)
	endtask : wait_irq

	// one frame; a byte never taken ends its wait quietly after 600 cycles
	task automatic send(input logic [7:0] q[$], input logic wake);
		int n;
		h_wake = wake;
		hq.delete();
		dq.delete();
		foreach (q[i]) begin
			h_tx_valid = 1'b1;
			h_tx_byte = q[i];
			h_tx_last = (i == q.size() - 1);
			n = 0;
			do begin
				tick(1);
				n++;
			end while (h_tx_ready !== 1'b1 && n < 600);
			h_wake = 1'b0;
		end
		h_tx_valid = 1'b0;
		n = 0;
		while (spi_wake_if_i.spi_cs_n !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		tick(4);
	endtask : send

	task automatic stop_test;
		$display("mismatches %0d of %0d checks", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test

	// main sequence
	initial begin
		{h_tx_valid, h_tx_last, h_wake, h_req_wired, h_low_batt} = '0;
		{d_resp_ready, d_tx_load, d_sec_event, d_tgt_active, d_rf_field} = '0;
		h_tx_byte = 8'h00;
		d_tx_byte = 8'hA5;
		i_sys_rst = 1'b1;
		tick(3);
		i_sys_rst = 1'b0;
		tick(2);
		`CHK(spi_wake_if_i.host_irq_n, 1'b1)
		`CHK(d_awake, 1'b0)
		`CHK(d_mode, 2'h1)
		pulse(d_sec_event);
		wait_irq(1'b1, 20);
		// a second event after the indicator leaves only the status command to release
		fork
			send('{`IND_WRITE, `TFI_HOST, `CC_GEN_STATUS}, 1'b0);
			begin
				tick(120);
				pulse(d_sec_event);
			end
		join
		`CHK(dq.size(), 3)
		`CHK(dq[2], `CC_GEN_STATUS)
		wait_irq(1'b0, 20);
		send('{`IND_WRITE, `TFI_HOST, `CC_TARGET_INIT}, 1'b0);
		pulse(d_resp_ready);
		wait_irq(1'b1, 20);
		fork
			send('{`IND_READ, 8'h00, 8'h00}, 1'b0);
			begin
				tick(4);
				pulse(d_tx_load);
			end
		join
		`CHK(hq.size(), 3)
		`CHK(hq[2], 8'hA5)
		wait_irq(1'b0, 20);
		tick(20);
		`CHK(d_awake, 1'b1)
		tick(SLP);
		`CHK(d_awake, 1'b0)
		pulse(d_tgt_active);
		wait_irq(1'b1, 20);
		send('{`IND_READ, 8'h00}, 1'b0);
		wait_irq(1'b0, 20);
		tick(SLP + 20);
		`CHK(d_awake, 1'b0)
		h_req_wired = 1'b1;
		send('{`IND_WRITE, `TFI_HOST, 8'h02}, 1'b1);
		`CHK(d_awake, 1'b1)
		`CHK(h_irq, 1'b0)
		// sleep is refused only once virtual card has been configured
		foreach (modes[k]) begin
			send('{`IND_WRITE, `TFI_HOST, `CC_SECURE_CFG, modes[k], `SEC_NO_TIMEOUT},
				1'b0);
			`CHK(d_mode, k[1:0])
			if (k == 1) begin
				send('{`IND_WRITE, `TFI_HOST, `CC_SLEEP}, 1'b0);
				`CHK(refused_n, 1)
			end
		end
		h_low_batt = 1'b1;
		pulse(d_sec_event);
		tick(20);
		`CHK(h_irq, 1'b0)
		send('{`IND_WRITE, `TFI_HOST, `CC_GEN_STATUS}, 1'b0);
		`CHK(last_lead >= OSC, 1'b1)
		pulse(d_resp_ready);
		wait_irq(1'b1, 20);
		send('{`IND_READ, 8'h00}, 1'b0);
		wait_irq(1'b0, 20);
		stop_test();
	end
endmodule : test_spi_host_wakeup_handshake
